// ---- include/cpu_bit_defs.svh ----
`ifndef CPU_BIT_DEFS_SVH
`define CPU_BIT_DEFS_SVH

// APB byte offsets of the block's registers.
`define OFS_CMD 8'h00
`define OFS_STAT 8'h04
`define OFS_PC 8'h08
`define OFS_WSEL 8'h0c
`define OFS_WDAT 8'h10
`define OFS_CYC 8'h14

// Command word fields.
`define CMD_W 26
`define CMD_OP_LSB 0
`define CMD_RD_LSB 5
`define CMD_RR_LSB 10
`define CMD_BIT_LSB 15
`define CMD_K_LSB 18

// Status word fields.
`define STAT_BUSY 8
`define STAT_TAKEN 9

// Window select fields.
`define WSEL_W 18
`define WSEL_SPACE_LSB 16

// Bit positions inside the status flags register.
`define FLG_C 3'h0
`define FLG_Z 3'h1
`define FLG_N 3'h2
`define FLG_V 3'h3
`define FLG_S 3'h4
`define FLG_H 3'h5
`define FLG_T 3'h6
`define FLG_I 3'h7

// Indirect load: mode in constant bits 1:0, pointer choice in bit 2.
`define LD_PLAIN 2'h0
`define LD_POSTINC 2'h1
`define LD_PREDEC 2'h2
`define LD_Y_BIT 2

// Low registers of the X and Y pointer pairs.
`define PTR_X_LO 5'h1a
`define PTR_Y_LO 5'h1c

// Reset values.
`define PC_RST 16'h0000
`define FLAGS_RST 8'h00

`endif

// ---- include/cpu_bit_pkg.sv ----
package cpu_bit_pkg;

	typedef enum logic [4:0] {
		OP_BRANCH_ON_NO_OVERFLOW,
		OP_BRANCH_ON_IRQ_ENABLED,
		OP_BRANCH_ON_IRQ_DISABLED,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_LOGICAL_LEFT_SHIFT,
		OP_LOGICAL_RIGHT_SHIFT,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_ARITHMETIC_RIGHT_SHIFT,
		OP_NIBBLE_SWAP,
		OP_STATUS_BIT_SET_INDEXED,
		OP_STATUS_BIT_CLEAR_INDEXED,
		OP_REGISTER_BIT_TO_TRANSFER_FLAG,
		OP_TRANSFER_FLAG_TO_REGISTER_BIT,
		OP_GLOBAL_IRQ_ON,
		OP_GLOBAL_IRQ_OFF,
		OP_REGISTER_COPY,
		OP_REGISTER_PAIR_COPY,
		OP_IMMEDIATE_LOAD,
		OP_INDIRECT_LOAD
	} op_t;

	typedef enum logic [1:0] {ST_IDLE, ST_ONE, ST_TWO} state_t;

	typedef enum logic [1:0] {SP_REG, SP_IO, SP_MEM} space_t;

endpackage

// ---- core/shift_unit.sv ----
module shift_unit
	import cpu_bit_pkg::*;
(
	input wire op_t op,
	input wire logic [7:0] din,
	input wire logic cin,
	output logic [7:0] dout,
	output logic cOut,
	output logic zOut,
	output logic nOut,
	output logic vOut
);

	// Shifts and rotates with their carry, zero, negative and overflow.
	always_comb begin
		dout = din;
		cOut = cin;
		unique case (op)
			OP_LOGICAL_LEFT_SHIFT: {cOut, dout} = {din, 1'b0};
			OP_ROTATE_LEFT_CARRY: {cOut, dout} = {din, cin};
			OP_LOGICAL_RIGHT_SHIFT: {dout, cOut} = {1'b0, din};
			OP_ROTATE_RIGHT_CARRY: {dout, cOut} = {cin, din};
			OP_ARITHMETIC_RIGHT_SHIFT: {dout, cOut} = {din[7], din};
			default: ;
		endcase
		nOut = dout[7];
		zOut = (dout == 8'h00);
		vOut = nOut ^ cOut;
	end

endmodule // shift_unit

// ---- core/cpu_bit_flag_transfer_ops.sv ----
// Summary of operation
// - No-overflow branch jumps by offset plus one if V is 0, 1 or 2 cycles.
// - Irq-enabled branch jumps if I is 1, irq-disabled if I is 0; 1-2 cycles.
// - I/O bit set and clear force one I/O register bit, no flags, 2 cycles.
// - Left shift feeds 0 or C to bit 0, bit 7 to C, sets Z C N V, 1 cycle.
// - Right shift feeds 0 or C to bit 7, bit 0 to C, sets Z C N V, 1 cycle.
// - Arithmetic right shift keeps bit 7, sets Z C N V; swap keeps flags.
// - Any status flag can be set or cleared by index, alone, in 1 cycle.
// - Global irq on sets I and global irq off clears I, each in 1 cycle.
// - Register bit to transfer flag copies one register bit into T, 1 cycle.
// - Transfer flag to register bit writes T into one bit and keeps flags.
// - Indirect load via X or Y reads at the pointer, post-increment adds 1.
// - Pre-decrement load lowers pointer first, then reads at it, 2 cycles.
//
// Implementation choices: register access over APB and the register addresses.
`include "cpu_bit_defs.svh"

module cpu_bit_flag_transfer_ops
	import cpu_bit_pkg::*;
#(
	parameter int DMEM_AW = 8,
	parameter int IO_AW = 6
)(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// Memory sizes the address fields can serve.
	if (DMEM_AW < 1 || DMEM_AW > 16) begin : gBadMem
		$error("DMEM_AW must lie between 1 and 16");
	end
	if (IO_AW < 1 || IO_AW > 6) begin : gBadIo
		$error("IO_AW must lie between 1 and 6");
	end

	// Architectural state.
	logic [7:0] regs [32];
	logic [7:0] ioRegs [2**IO_AW];
	logic [7:0] dmem [2**DMEM_AW];
	logic [7:0] statusFlags_r;
	logic [15:0] pc_r;
	logic [`CMD_W-1:0] cmd_r;
	logic [`WSEL_W-1:0] wsel_r;
	logic [15:0] cyc_r;
	logic taken_r;
	state_t state_r;

	// Decoded command fields and bus strobes.
	op_t op;
	logic [4:0] rd;
	logic [4:0] rr;
	logic [2:0] bitSel;
	logic [7:0] kVal;
	logic [1:0] ldMode;
	logic [4:0] ptrLo;
	logic [15:0] ptr;
	logic [IO_AW-1:0] ioAddr;
	logic busy;
	logic apbAccess;
	logic wrCommit;
	logic cmdWrite;
	logic pcWrite;
	logic statWrite;
	logic wselWrite;
	logic winWrite;
	space_t wSpace;
	logic [15:0] wIdx;
	logic brTaken;
	logic twoCycle;
	logic [31:0] rdData;
	// Shift unit results.
	logic [7:0] shOut;
	logic shC;
	logic shZ;
	logic shN;
	logic shV;

	// Returns a byte with one bit forced to the given value.
	function automatic logic [7:0] setBit(input logic [7:0] v,
			input logic [2:0] idx, input logic val);
		logic [7:0] r;
		r = v;
		r[idx] = val;
		return r;
	endfunction

	// True for byte offsets that hold a register.
	function automatic logic isMapped(input logic [7:0] a);
		return a inside {`OFS_CMD, `OFS_STAT, `OFS_PC, `OFS_WSEL,
			`OFS_WDAT, `OFS_CYC};
	endfunction

	// Command word fields.
	assign op = op_t'(cmd_r[`CMD_OP_LSB +: 5]);
	assign rd = cmd_r[`CMD_RD_LSB +: 5];
	assign rr = cmd_r[`CMD_RR_LSB +: 5];
	assign bitSel = cmd_r[`CMD_BIT_LSB +: 3];
	assign kVal = cmd_r[`CMD_K_LSB +: 8];
	assign ldMode = kVal[1:0];
	assign ioAddr = kVal[IO_AW-1:0];

	// Pointer pair chosen by the indirect load.
	assign ptrLo = kVal[`LD_Y_BIT] ? `PTR_Y_LO : `PTR_X_LO;
	assign ptr = {regs[ptrLo + 5'h01], regs[ptrLo]};

	// Bus qualifiers; a write lands only on the edge that sees pready.
	assign busy = (state_r != ST_IDLE);
	assign apbAccess = psel & penable;
	assign wrCommit = apbAccess & pready & pwrite & ~pslverr;
	assign wSpace = space_t'(wsel_r[`WSEL_SPACE_LSB +: 2]);
	assign wIdx = wsel_r[15:0];

	// Accepted writes, one strobe per register offset except the read-only OFS_CYC.
	assign cmdWrite = wrCommit && paddr == `OFS_CMD;
	assign pcWrite = wrCommit && paddr == `OFS_PC;
	assign statWrite = wrCommit && paddr == `OFS_STAT;
	assign wselWrite = wrCommit && paddr == `OFS_WSEL;
	assign winWrite = wrCommit && paddr == `OFS_WDAT;

	// Branch condition and the length of the current command.
	// Only a taken branch stretches a branch to two cycles.
	always_comb begin
		unique case (op)
			OP_BRANCH_ON_NO_OVERFLOW: brTaken = ~statusFlags_r[`FLG_V];
			OP_BRANCH_ON_IRQ_ENABLED: brTaken = statusFlags_r[`FLG_I];
			OP_BRANCH_ON_IRQ_DISABLED: brTaken = ~statusFlags_r[`FLG_I];
			default: brTaken = 1'b0;
		endcase
		twoCycle = brTaken || op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
			OP_INDIRECT_LOAD};
	end

	// Read data for the addressed register.
	always_comb begin
		rdData = 32'h0000_0000;
		unique case (paddr)
			`OFS_CMD: rdData[`CMD_W-1:0] = cmd_r;
			`OFS_STAT: begin
				rdData[7:0] = statusFlags_r;
				rdData[`STAT_BUSY] = busy;
				rdData[`STAT_TAKEN] = taken_r;
			end
			`OFS_PC: rdData[15:0] = pc_r;
			`OFS_WSEL: rdData[`WSEL_W-1:0] = wsel_r;
			`OFS_WDAT: begin
				unique case (wSpace)
					SP_REG: rdData[7:0] = regs[wIdx[4:0]];
					SP_IO: rdData[7:0] = ioRegs[wIdx[IO_AW-1:0]];
					SP_MEM: rdData[7:0] = dmem[wIdx[DMEM_AW-1:0]];
					default: rdData[7:0] = 8'h00;
				endcase
			end
			`OFS_CYC: rdData[15:0] = cyc_r;
			default: rdData = 32'h0000_0000;
		endcase
	end

	// APB slave: one wait state, then pready with data or error.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (apbAccess && !pready) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0000_0000 : rdData;
			// Writes are refused while a command runs.
			pslverr <= !isMapped(paddr) || (pwrite && busy) ||
				(pwrite && paddr == `OFS_CYC);
		end else begin
			// Read data stands only with pready and is zero otherwise.
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
	end

	// Command and window select registers.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cmd_r <= '0;
			wsel_r <= '0;
		end else begin
			if (cmdWrite)
				cmd_r <= pwdata[`CMD_W-1:0];
			if (wselWrite)
				wsel_r <= pwdata[`WSEL_W-1:0];
		end
	end

	// Sequencer: a command runs for one or two cycles.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				// Writes are refused while busy, so only an idle core starts.
				ST_IDLE: if (cmdWrite) begin
					state_r <= ST_ONE;
				end
				ST_ONE: state_r <= twoCycle ? ST_TWO : ST_IDLE;
				ST_TWO: state_r <= ST_IDLE;
			endcase
		end
	end

	// Cycles spent by the latest command, and its branch outcome.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cyc_r <= 16'h0000;
			taken_r <= 1'b0;
		end else if (cmdWrite) begin
			// The count restarts with every accepted command.
			cyc_r <= 16'h0000;
			taken_r <= 1'b0;
		end else if (busy) begin
			cyc_r <= cyc_r + 16'h0001;
			if (state_r == ST_ONE)
				taken_r <= brTaken;
		end
	end

	// Program counter: taken branches add the signed offset plus one.
	// Everything else, a not-taken branch included, steps by one.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pc_r <= `PC_RST;
		end else if (pcWrite) begin
			pc_r <= pwdata[15:0];
		end else if (state_r == ST_ONE && !twoCycle) begin
			pc_r <= pc_r + 16'h0001;
		end else if (state_r == ST_TWO) begin
			if (brTaken)
				pc_r <= pc_r + {{8{kVal[7]}}, kVal} + 16'h0001;
			else
				pc_r <= pc_r + 16'h0001;
		end
	end

	// Shift and rotate datapath for the register named by rd.
	shift_unit uShift (
		.op(op),
		.din(regs[rd]),
		.cin(statusFlags_r[`FLG_C]),
		.dout(shOut),
		.cOut(shC),
		.zOut(shZ),
		.nOut(shN),
		.vOut(shV)
	);

	// Status flags register; a bus write never meets a running command,
	// because writes are refused while busy.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			statusFlags_r <= `FLAGS_RST;
		end else if (statWrite) begin
			statusFlags_r <= pwdata[7:0];
		end else if (state_r == ST_ONE) begin
			unique case (op)
				OP_LOGICAL_LEFT_SHIFT, OP_ROTATE_LEFT_CARRY,
				OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_RIGHT_CARRY,
				OP_ARITHMETIC_RIGHT_SHIFT: begin
					statusFlags_r[`FLG_C] <= shC;
					statusFlags_r[`FLG_Z] <= shZ;
					statusFlags_r[`FLG_N] <= shN;
					statusFlags_r[`FLG_V] <= shV;
				end
				OP_STATUS_BIT_SET_INDEXED:
					statusFlags_r <= setBit(statusFlags_r, bitSel, 1'b1);
				OP_STATUS_BIT_CLEAR_INDEXED:
					statusFlags_r <= setBit(statusFlags_r, bitSel, 1'b0);
				OP_GLOBAL_IRQ_ON: statusFlags_r[`FLG_I] <= 1'b1;
				OP_GLOBAL_IRQ_OFF: statusFlags_r[`FLG_I] <= 1'b0;
				OP_REGISTER_BIT_TO_TRANSFER_FLAG:
					statusFlags_r[`FLG_T] <= regs[rr][bitSel];
				default: ;
			endcase
		end
	end

	// Register file writes from the bus window and from commands.
	always_ff @(posedge ref_clk) begin
		if (winWrite && wSpace == SP_REG) begin
			regs[wIdx[4:0]] <= pwdata[7:0];
		end else if (state_r == ST_ONE) begin
			unique case (op)
				OP_LOGICAL_LEFT_SHIFT, OP_ROTATE_LEFT_CARRY,
				OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_RIGHT_CARRY,
				OP_ARITHMETIC_RIGHT_SHIFT:
					regs[rd] <= shOut;
				OP_NIBBLE_SWAP:
					regs[rd] <= {regs[rd][3:0], regs[rd][7:4]};
				OP_TRANSFER_FLAG_TO_REGISTER_BIT:
					regs[rd] <= setBit(regs[rd], bitSel,
						statusFlags_r[`FLG_T]);
				OP_REGISTER_COPY: regs[rd] <= regs[rr];
				OP_REGISTER_PAIR_COPY: begin
					regs[{rd[4:1], 1'b0}] <= regs[{rr[4:1], 1'b0}];
					regs[{rd[4:1], 1'b1}] <= regs[{rr[4:1], 1'b1}];
				end
				OP_IMMEDIATE_LOAD: regs[rd] <= kVal;
				// Pre-decrement lowers the pointer in the first cycle, so the
				// read in the second cycle already uses the new address.
				OP_INDIRECT_LOAD: if (ldMode == `LD_PREDEC) begin
					{regs[ptrLo + 5'h01], regs[ptrLo]} <= ptr - 16'h0001;
				end
				default: ;
			endcase
		end else if (state_r == ST_TWO && op == OP_INDIRECT_LOAD) begin
			regs[rd] <= dmem[ptr[DMEM_AW-1:0]];
			if (ldMode == `LD_POSTINC)
				{regs[ptrLo + 5'h01], regs[ptrLo]} <= ptr + 16'h0001;
		end
	end

	// I/O registers: bus window writes and single-bit set or clear.
	// The bit operation rewrites the whole byte with one bit forced.
	always_ff @(posedge ref_clk) begin
		if (winWrite && wSpace == SP_IO) begin
			ioRegs[wIdx[IO_AW-1:0]] <= pwdata[7:0];
		end else if (state_r == ST_TWO &&
				op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR}) begin
			ioRegs[ioAddr] <= setBit(ioRegs[ioAddr], bitSel,
				op == OP_IO_BIT_SET);
		end
	end

	// Data memory, written only through the bus window.
	// Commands only read it, so a load sees the last window write.
	always_ff @(posedge ref_clk) begin
		if (winWrite && wSpace == SP_MEM)
			dmem[wIdx[DMEM_AW-1:0]] <= pwdata[7:0];
	end

endmodule // cpu_bit_flag_transfer_ops

// ---- testbench/cpu_bit_checker.sv ----
`include "cpu_bit_defs.svh"
module cpu_bit_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	// All checks sample on the core clock and rest during reset.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Answer timing and qualification of every bus access.
	property p_rdy_acc; pready |-> psel && penable; endproperty
	a_rdy_acc: assert property (p_rdy_acc) else $error("stray pready");
	property p_rdy_lat; psel && penable && !pready |=> pready; endproperty
	a_rdy_lat: assert property (p_rdy_lat) else $error("late pready");
	property p_rdy_one; pready |=> !pready; endproperty
	a_rdy_one: assert property (p_rdy_one) else $error("long pready");
	property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("idle data");
	property p_err_q; pslverr |-> pready; endproperty
	a_err_q: assert property (p_err_q) else $error("stray error");
	// Refusals and the cycle counter.
	property p_unmap;
		pready && paddr > `OFS_CYC |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped ok");
	property p_cyc_wr; pready && pwrite && paddr == `OFS_CYC |-> pslverr;
	endproperty
	a_cyc_wr: assert property (p_cyc_wr) else $error("cyc written");
	property p_cyc_rd;
		pready && !pwrite && paddr == `OFS_CYC |-> prdata[31:2] == 30'h0;
	endproperty
	a_cyc_rd: assert property (p_cyc_rd) else $error("cyc range");
	property p_rd_ok;
		pready && !pwrite && paddr < `OFS_CYC && paddr[1:0] == 2'h0
			|-> !pslverr;
	endproperty
	a_rd_ok: assert property (p_rd_ok) else $error("read refused");
endmodule // cpu_bit_checker

bind cpu_bit_flag_transfer_ops cpu_bit_checker u_chk (.ref_clk(ref_clk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));

// ---- testbench/tb_cpu_bit_flag_transfer_ops.sv ----
`include "cpu_bit_defs.svh"
module tb_cpu_bit_flag_transfer_ops;
	timeunit 1ns;
	timeprecision 1ns;
	import cpu_bit_pkg::*;
	logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, e, c, t;
	logic [7:0] paddr = 8'h00, d, r, f;
	logic [31:0] pwdata = 32'h0, prdata, q;
	int n_mismatch = 0, comparisons = 0;
	op_t sop [6] = '{OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
		OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
		OP_ARITHMETIC_RIGHT_SHIFT, OP_NIBBLE_SWAP};
	op_t bop [3] = '{OP_BRANCH_ON_NO_OVERFLOW, OP_BRANCH_ON_IRQ_ENABLED,
		OP_BRANCH_ON_IRQ_DISABLED};
	logic [7:0] bfl [3] = '{8'h08, 8'h80, 8'h80};
	logic bwant [3] = '{1'b0, 1'b1, 1'b0};

	cpu_bit_flag_transfer_ops DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// Free-running 25 MHz core clock.
	initial forever #20 ref_clk = ~ref_clk;

	// Counts a comparison and reports a mismatch at once.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; read data and error are taken with pready.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Window access to registers, I/O registers and data memory, and status flag access.
	task sr(input space_t s, input logic [15:0] i, input logic [7:0] v);
		apb(1'b1, `OFS_WSEL, {14'h0, s, i});
		apb(1'b1, `OFS_WDAT, {24'h0, v});
	endtask
	task gr(input space_t s, input logic [15:0] i, input logic [7:0] x);
		apb(1'b1, `OFS_WSEL, {14'h0, s, i});
		apb(1'b0, `OFS_WDAT, 32'h0);
		chk(q, {24'h0, x});
	endtask
	task gf(input logic [7:0] x);
		apb(1'b0, `OFS_STAT, 32'h0);
		chk({24'h0, q[7:0]}, {24'h0, x});
	endtask
	task sf(input logic [7:0] v);
		apb(1'b1, `OFS_STAT, {24'h0, v});
	endtask

	// Issues a command, waits for idle and checks the cycle count.
	task run(input op_t o, input logic [4:0] rd, input logic [4:0] rr,
		input logic [2:0] b, input logic [7:0] k, input logic [31:0] n);
		apb(1'b1, `OFS_CMD, {6'h0, k, b, rr, rd, o});
		do apb(1'b0, `OFS_STAT, 32'h0); while (q[`STAT_BUSY] !== 1'b0);
		apb(1'b0, `OFS_CYC, 32'h0);
		chk(q, n);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task final_report;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		repeat (40000) @(posedge ref_clk);
		n_mismatch++;
		final_report;
	end

	// Main sequence.
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		gf(8'h00);
		apb(1'b0, `OFS_PC, 32'h0);
		chk(q, 32'h0);
		for (int i = 0; i < 6; i++) begin
			for (int j = 0; j < 2; j++) begin
				d = j ? 8'h80 : 8'h81;
				case (sop[i])
					OP_LOGICAL_LEFT_SHIFT: {c, r} = {d, 1'b0};
					OP_LOGICAL_RIGHT_SHIFT: {r, c} = {1'b0, d};
					OP_ROTATE_LEFT_CARRY: {c, r} = {d, 1'b1};
					OP_ROTATE_RIGHT_CARRY: {r, c} = {1'b1, d};
					OP_ARITHMETIC_RIGHT_SHIFT: {r, c} = {d[7], d};
					default: {c, r} = {1'b1, d[3:0], d[7:4]};
				endcase
				f = 8'h31;
				if (sop[i] != OP_NIBBLE_SWAP)
					f = {4'h3, r[7] ^ c, r[7], r == 8'h0, c};
				sr(SP_REG, 16'h1, d);
				sf(8'h31);
				run(sop[i], 5'h1, 5'h1, 3'h0, 8'h0, 32'h1);
				gr(SP_REG, 16'h1, r);
				gf(f);
			end
		end
		for (int i = 0; i < 8; i++) begin
			sf(8'h00);
			run(OP_STATUS_BIT_SET_INDEXED, 5'h0, 5'h0, 3'(i), 8'h0, 32'h1);
			gf(8'h01 << i);
			sf(8'hff);
			run(OP_STATUS_BIT_CLEAR_INDEXED, 5'h0, 5'h0, 3'(i), 8'h0, 32'h1);
			gf(~(8'h01 << i));
		end
		sf(8'h7f);
		run(OP_GLOBAL_IRQ_ON, 5'h0, 5'h0, 3'h0, 8'h0, 32'h1);
		gf(8'hff);
		run(OP_GLOBAL_IRQ_OFF, 5'h0, 5'h0, 3'h0, 8'h0, 32'h1);
		gf(8'h7f);
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 2; j++) begin
				f = j ? bfl[i] : 8'h00;
				t = (j == bwant[i]);
				sf(f);
				apb(1'b1, `OFS_PC, 32'h10);
				run(bop[i], 5'h0, 5'h0, 3'h0, 8'hfb, t ? 2 : 1);
				apb(1'b0, `OFS_PC, 32'h0);
				chk(q, t ? 32'h0c : 32'h11);
				gf(f);
				chk({31'h0, q[`STAT_TAKEN]}, {31'h0, t});
			end
		end
		sr(SP_IO, 16'h3, 8'h5a);
		sf(8'h55);
		run(OP_IO_BIT_SET, 5'h0, 5'h0, 3'h5, 8'h03, 32'h2);
		gr(SP_IO, 16'h3, 8'h7a);
		run(OP_IO_BIT_CLEAR, 5'h0, 5'h0, 3'h1, 8'h03, 32'h2);
		gr(SP_IO, 16'h3, 8'h78);
		gf(8'h55);
		sr(SP_REG, 16'h2, 8'h40);
		sr(SP_REG, 16'h3, 8'h00);
		sf(8'h00);
		run(OP_REGISTER_BIT_TO_TRANSFER_FLAG, 5'h2, 5'h2, 3'h6, 8'h0, 32'h1);
		gf(8'h40);
		run(OP_TRANSFER_FLAG_TO_REGISTER_BIT, 5'h3, 5'h3, 3'h1, 8'h0, 32'h1);
		gr(SP_REG, 16'h3, 8'h02);
		run(OP_REGISTER_BIT_TO_TRANSFER_FLAG, 5'h2, 5'h2, 3'h0, 8'h0, 32'h1);
		gf(8'h00);
		sr(SP_REG, 16'h6, 8'h12);
		sr(SP_REG, 16'h7, 8'h34);
		run(OP_REGISTER_COPY, 5'h4, 5'h2, 3'h0, 8'h0, 32'h1);
		gr(SP_REG, 16'h4, 8'h40);
		run(OP_REGISTER_PAIR_COPY, 5'h8, 5'h6, 3'h0, 8'h0, 32'h1);
		gr(SP_REG, 16'h8, 8'h12);
		gr(SP_REG, 16'h9, 8'h34);
		run(OP_IMMEDIATE_LOAD, 5'h5, 5'h0, 3'h0, 8'hc3, 32'h1);
		gr(SP_REG, 16'h5, 8'hc3);
		sr(SP_REG, 16'h1a, 8'h10);
		sr(SP_REG, 16'h1b, 8'h00);
		sr(SP_REG, 16'h1c, 8'h20);
		sr(SP_REG, 16'h1d, 8'h00);
		sr(SP_MEM, 16'h10, 8'ha5);
		sr(SP_MEM, 16'h11, 8'h77);
		sr(SP_MEM, 16'h1f, 8'h3c);
		run(OP_INDIRECT_LOAD, 5'ha, 5'h0, 3'h0, 8'h01, 32'h2);
		gr(SP_REG, 16'ha, 8'ha5);
		gr(SP_REG, 16'h1a, 8'h11);
		run(OP_INDIRECT_LOAD, 5'hc, 5'h0, 3'h0, 8'h00, 32'h2);
		gr(SP_REG, 16'hc, 8'h77);
		gr(SP_REG, 16'h1a, 8'h11);
		run(OP_INDIRECT_LOAD, 5'hb, 5'h0, 3'h0, 8'h06, 32'h2);
		gr(SP_REG, 16'hb, 8'h3c);
		gr(SP_REG, 16'h1c, 8'h1f);
		gf(8'h00);
		apb(1'b0, 8'h20, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, `OFS_CYC, 32'h5);
		chk({31'h0, e}, 32'h1);
		final_report;
	end
endmodule // tb_cpu_bit_flag_transfer_ops
